/* File: dcrb_host_model.sv */
// Host side model: serial clock, chip select and frame check results
`timescale 1ns/1ps
`default_nettype none
module dcrb_host_model (
	input wire logic clk_in,
	output var logic sclk_out,
	output var logic cs_n_out,
	output var logic done_out,
	output var logic bad_out
);
	// Idle state: serial clock still, device deselected
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		done_out = 1'b0;
		bad_out = 1'b0;
	end
	// One frame whose check word is good or bad; result line flips once released
	task automatic frame(input logic b);
		@(posedge clk_in);
		done_out <= 1'b1;
		bad_out <= b;
		@(posedge clk_in);
		done_out <= 1'b0;
		bad_out <= ~b;
	endtask
	// Move serial clock and select, then give the sampler time to see it
	task automatic pins(input logic s, input logic c);
		@(posedge clk_in);
		sclk_out <= s;
		cs_n_out <= c;
		repeat (4) @(posedge clk_in);
		#1;
	endtask
endmodule
`default_nettype wire

/* File: dcrb_pkg.sv */
// Package of offsets, field positions and reset values for the DAC configuration register bank
package dcrb_pkg;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [5:0] DCRB_OFS_NO_OPERATION = 6'h00;
	localparam logic [5:0] DCRB_OFS_DAC_OUTPUT_CODE = 6'h01;
	localparam logic [5:0] DCRB_OFS_GENERAL_CONFIGURATION = 6'h02;
	localparam logic [5:0] DCRB_OFS_IRQ_STATUS = 6'h30;
	localparam logic [5:0] DCRB_OFS_IRQ_CLEAR = 6'h31;
	localparam logic [5:0] DCRB_OFS_IRQ_ENABLE = 6'h32;

	// ----------------------------------------------------------------
	// Reset values and masks
	// ----------------------------------------------------------------
	localparam logic [15:0] DCRB_RST_DAC_OUTPUT_CODE = 16'h0000;
	localparam logic [15:0] DCRB_RST_CONFIG = 16'h0036;
	localparam logic [15:0] DCRB_CONFIG_WRITE_MASK = 16'h7bff;
	localparam logic [1:0] DCRB_RST_IRQ = 2'h0;

	// ----------------------------------------------------------------
	// Configuration field positions
	// ----------------------------------------------------------------
	localparam int DCRB_BIT_CRC_THR_HI = 14;
	localparam int DCRB_BIT_CRC_THR_LO = 13;
	localparam int DCRB_BIT_CLOCK_OUT_DIVIDE = 12;
	localparam int DCRB_BIT_CLOCK_OUT_ENABLE = 11;
	localparam int DCRB_BIT_BREAK_IRQ_ENABLE = 9;
	localparam int DCRB_BIT_IRQ_PIN_ENABLE = 8;
	localparam int DCRB_BIT_CLEAR_PIN_ENABLE = 7;
	localparam int DCRB_BIT_UART_DISABLE = 6;
	localparam int DCRB_BIT_UART_BAUD = 5;
	localparam int DCRB_BIT_CRC_ENABLE = 4;
	localparam int DCRB_BIT_IRQ_POLARITY = 3;
	localparam int DCRB_BIT_IRQ_LEVEL_MODE = 2;
	localparam int DCRB_BIT_SERIAL_OUT_TRISTATE = 1;
	localparam int DCRB_BIT_SERIAL_OUT_EARLY = 0;

	// ----------------------------------------------------------------
	// Interrupt status bits and counts
	// ----------------------------------------------------------------
	localparam int DCRB_EVT_CRC_FAULT = 0;
	localparam int DCRB_EVT_CLEAR_REQ = 1;
	localparam int DCRB_CLOCK_OUT_DIVIDE = 128;
	localparam logic [5:0] DCRB_HALF_DIVIDE = 6'(DCRB_CLOCK_OUT_DIVIDE / 2 - 1);
	localparam logic [3:0] DCRB_CRC_CNT_MAX = 4'h8;
endpackage

/* File: dcrb_register_bank.sv */
// Register bank of the DAC front end: output code, configuration and the pins it steers
// What this block does
// - Writes to offset zero change nothing; reads there return zero.
// - Offset one holds the sixteen-bit output code, reset to zero.
// - Configuration at offset two resets to 0x0036; bits 15 and 10 read zero.
// - CRC fault sets after 1, 2, 4 or 8 consecutive failing frames.
// - Divide bit set gives oscillator over 128 on the clock output pin.
// - Clock output pin carries the oscillator only while its enable is set.
// - Break-mode interrupt enable sends interrupts as break on the UART transmit output.
// - Dedicated interrupt pin works only while its enable bit is set.
// - Clear-pin enable makes serial input a clear request in break mode.
// - UART disable bit at one turns the UART off.
// - Baud bit picks 1200 baud plain or 9600 baud with break mode.
// - CRC is checked on serial frames while CRC enable is set.
// - Interrupt pin is active low when polarity is zero, high when one.
// - Interrupt pin gives pulses when level mode is zero, levels when one.
// - Serial out tristate set keeps output undriven; clear drives during select.
// - Early launch moves serial output launch to the falling serial clock edge.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module dcrb_register_bank
	import dcrb_pkg::*;
(
	input wire logic CLK_SYS_IN,
	input wire logic RST_N_IN,
	input wire logic [5:0] REG_ADDR_IN,
	input wire logic [15:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	output logic [15:0] REG_RDATA_OUT,
	input wire logic CRC_FRAME_DONE_IN,
	input wire logic CRC_FRAME_BAD_IN,
	output logic CRC_CHECK_ENABLE_OUT,
	input wire logic OSC_LEVEL_IN,
	output logic CLOCK_OUTPUT_PIN_OUT,
	input wire logic UART_TX_DATA_IN,
	output logic UART_TRANSMIT_OUTPUT_OUT,
	output logic UART_ENABLE_OUT,
	output logic UART_BAUD_9600_OUT,
	input wire logic SDI_IN,
	output logic CLEAR_STATE_OUT,
	input wire logic SCLK_IN,
	input wire logic CS_N_IN,
	input wire logic SDO_DATA_IN,
	output logic SDO_OUT,
	output logic SDO_OE_N_OUT,
	output logic IRQ_PIN_OUT,
	output logic INT_OUT,
	output logic [15:0] VOLTAGE_OUTPUT_CODE_OUT
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [15:0] dac_output_code;
	logic [15:0] general_configuration;
	logic [1:0] irq_status;
	logic [1:0] irq_enable;
	logic [1:0] event_set;
	logic [3:0] crc_fail_count;
	logic [3:0] crc_threshold;
	logic [3:0] next_crc_fail_count;
	logic osc_prev;
	logic [5:0] osc_div_count;
	logic osc_div_level;
	logic irq_pending;
	logic irq_pending_prev;
	logic irq_active;
	logic break_mode;
	logic sclk_prev;
	logic launch_edge;
	logic clear_req;

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	// Output code register; offset zero is decoded by no write logic so its writes vanish
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_N_IN) begin
			dac_output_code <= DCRB_RST_DAC_OUTPUT_CODE;
		end else if (REG_WR_IN && REG_ADDR_IN == DCRB_OFS_DAC_OUTPUT_CODE) begin
			dac_output_code <= REG_WDATA_IN;
		end
	end

	// Configuration register with reserved bits held at zero
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_N_IN) begin
			general_configuration <= DCRB_RST_CONFIG;
		end else if (REG_WR_IN && REG_ADDR_IN == DCRB_OFS_GENERAL_CONFIGURATION) begin
			general_configuration <= REG_WDATA_IN & DCRB_CONFIG_WRITE_MASK;
		end
	end

	// Interrupt enable register
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_N_IN) begin
			irq_enable <= DCRB_RST_IRQ;
		end else if (REG_WR_IN && REG_ADDR_IN == DCRB_OFS_IRQ_ENABLE) begin
			irq_enable <= REG_WDATA_IN[1:0];
		end
	end

	// Sticky status; a new event wins over a clear in the same cycle
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_N_IN) begin
			irq_status <= DCRB_RST_IRQ;
		end else if (REG_WR_IN && REG_ADDR_IN == DCRB_OFS_IRQ_CLEAR) begin
			irq_status <= (irq_status & ~REG_WDATA_IN[1:0]) | event_set;
		end else begin
			irq_status <= irq_status | event_set;
		end
	end

	// ----------------------------------------------------------------
	// Register reads
	// ----------------------------------------------------------------
	// Read data stand only in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_N_IN || !REG_RD_IN) begin
			REG_RDATA_OUT <= 16'h0000;
		end else begin
			unique case (REG_ADDR_IN)
				DCRB_OFS_NO_OPERATION: REG_RDATA_OUT <= 16'h0000;
				DCRB_OFS_DAC_OUTPUT_CODE: REG_RDATA_OUT <= dac_output_code;
				DCRB_OFS_GENERAL_CONFIGURATION: REG_RDATA_OUT <= general_configuration;
				DCRB_OFS_IRQ_STATUS: REG_RDATA_OUT <= {14'h0000, irq_status};
				DCRB_OFS_IRQ_ENABLE: REG_RDATA_OUT <= {14'h0000, irq_enable};
				default: REG_RDATA_OUT <= 16'h0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// CRC fault threshold
	// ----------------------------------------------------------------
	// Threshold is two to the power of the field
	always_comb begin
		crc_threshold = 4'h1 << general_configuration[DCRB_BIT_CRC_THR_HI:DCRB_BIT_CRC_THR_LO];
		next_crc_fail_count = crc_fail_count;
		if (CRC_FRAME_DONE_IN && general_configuration[DCRB_BIT_CRC_ENABLE]) begin
			if (!CRC_FRAME_BAD_IN) begin
				next_crc_fail_count = 4'h0;
			end else if (crc_fail_count != DCRB_CRC_CNT_MAX) begin
				next_crc_fail_count = crc_fail_count + 4'h1;
			end
		end
	end

	// Run of consecutive failing frames, saturating at eight
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_N_IN) begin
			crc_fail_count <= 4'h0;
		end else begin
			crc_fail_count <= next_crc_fail_count;
		end
	end

	assign CRC_CHECK_ENABLE_OUT = general_configuration[DCRB_BIT_CRC_ENABLE];

	// Events: fault when the run reaches the threshold, clear request on its rise
	assign event_set[DCRB_EVT_CRC_FAULT] = CRC_FRAME_DONE_IN && CRC_FRAME_BAD_IN
		&& general_configuration[DCRB_BIT_CRC_ENABLE]
		&& crc_fail_count != crc_threshold && next_crc_fail_count == crc_threshold;
	assign event_set[DCRB_EVT_CLEAR_REQ] = clear_req && !CLEAR_STATE_OUT;

	// ----------------------------------------------------------------
	// Clock output pin
	// ----------------------------------------------------------------
	// Toggle the divided level every 64 oscillator rising edges
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_N_IN) begin
			osc_prev <= 1'b0;
			osc_div_count <= 6'h00;
			osc_div_level <= 1'b0;
		end else begin
			osc_prev <= OSC_LEVEL_IN;
			if (OSC_LEVEL_IN && !osc_prev) begin
				if (osc_div_count == DCRB_HALF_DIVIDE) begin
					osc_div_count <= 6'h00;
					osc_div_level <= !osc_div_level;
				end else begin
					osc_div_count <= osc_div_count + 6'h01;
				end
			end
		end
	end

	// Registered pin, held low while disabled
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_N_IN || !general_configuration[DCRB_BIT_CLOCK_OUT_ENABLE]) begin
			CLOCK_OUTPUT_PIN_OUT <= 1'b0;
		end else if (general_configuration[DCRB_BIT_CLOCK_OUT_DIVIDE]) begin
			CLOCK_OUTPUT_PIN_OUT <= osc_div_level;
		end else begin
			CLOCK_OUTPUT_PIN_OUT <= OSC_LEVEL_IN;
		end
	end

	// ----------------------------------------------------------------
	// UART control
	// ----------------------------------------------------------------
	assign UART_ENABLE_OUT = !general_configuration[DCRB_BIT_UART_DISABLE];
	assign UART_BAUD_9600_OUT = general_configuration[DCRB_BIT_UART_BAUD];
	assign break_mode = UART_ENABLE_OUT && UART_BAUD_9600_OUT;
	assign irq_pending = |(irq_status & irq_enable);
	assign INT_OUT = irq_pending;

	// Break (held low) on the transmit line signals a pending interrupt
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_N_IN) begin
			UART_TRANSMIT_OUTPUT_OUT <= 1'b1;
		end else if (!UART_ENABLE_OUT) begin
			UART_TRANSMIT_OUTPUT_OUT <= 1'b1;
		end else if (break_mode && general_configuration[DCRB_BIT_BREAK_IRQ_ENABLE] && irq_pending) begin
			UART_TRANSMIT_OUTPUT_OUT <= 1'b0;
		end else begin
			UART_TRANSMIT_OUTPUT_OUT <= UART_TX_DATA_IN;
		end
	end

	// Serial input doubles as clear request only in break mode
	assign clear_req = general_configuration[DCRB_BIT_CLEAR_PIN_ENABLE] && break_mode && SDI_IN;

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_N_IN) begin
			CLEAR_STATE_OUT <= 1'b0;
		end else begin
			CLEAR_STATE_OUT <= clear_req;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt pin
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_N_IN) begin
			irq_pending_prev <= 1'b0;
		end else begin
			irq_pending_prev <= irq_pending;
		end
	end

	// Level mode follows pending; edge mode gives a one-cycle pulse on its rise
	assign irq_active = general_configuration[DCRB_BIT_IRQ_PIN_ENABLE]
		&& (general_configuration[DCRB_BIT_IRQ_LEVEL_MODE] ? irq_pending
		: (irq_pending && !irq_pending_prev));

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_N_IN) begin
			IRQ_PIN_OUT <= 1'b1;
		end else begin
			IRQ_PIN_OUT <= irq_active ~^ general_configuration[DCRB_BIT_IRQ_POLARITY];
		end
	end

	// ----------------------------------------------------------------
	// Serial data out
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_N_IN) begin
			sclk_prev <= 1'b0;
		end else begin
			sclk_prev <= SCLK_IN;
		end
	end

	// Launch edge is the rising one, or the falling one in early mode
	assign launch_edge = general_configuration[DCRB_BIT_SERIAL_OUT_EARLY]
		? (sclk_prev && !SCLK_IN) : (!sclk_prev && SCLK_IN);

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_N_IN) begin
			SDO_OUT <= 1'b0;
		end else if (launch_edge) begin
			SDO_OUT <= SDO_DATA_IN;
		end
	end

	// Enable low only while selected and tristate bit clear
	assign SDO_OE_N_OUT = general_configuration[DCRB_BIT_SERIAL_OUT_TRISTATE] || CS_N_IN;
	assign VOLTAGE_OUTPUT_CODE_OUT = dac_output_code;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_nop_reads_zero: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		REG_RD_IN && REG_ADDR_IN == DCRB_OFS_NO_OPERATION |=> REG_RDATA_OUT == 16'h0000)
		else $error("No-operation read not zero");
	chk_nop_write_inert: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		REG_WR_IN && REG_ADDR_IN == DCRB_OFS_NO_OPERATION |=> $stable(dac_output_code) && $stable(general_configuration))
		else $error("No-operation write changed state");
	chk_code_write_read: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		REG_WR_IN && REG_ADDR_IN == DCRB_OFS_DAC_OUTPUT_CODE ##1 REG_RD_IN && REG_ADDR_IN == DCRB_OFS_DAC_OUTPUT_CODE
		|=> REG_RDATA_OUT == $past(REG_WDATA_IN, 2))
		else $error("Output code readback mismatch");
	chk_reserved_zero: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		general_configuration[15] == 1'b0 && general_configuration[10] == 1'b0)
		else $error("Reserved configuration bit set");
	chk_config_reset: assert property (@(posedge CLK_SYS_IN)
		!RST_N_IN |=> general_configuration == 16'h0036)
		else $error("Configuration reset value wrong");
	chk_crc_single: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		general_configuration[14:13] == 2'h0 && general_configuration[4] && crc_fail_count == 4'h0
		&& CRC_FRAME_DONE_IN && CRC_FRAME_BAD_IN |=> irq_status[DCRB_EVT_CRC_FAULT])
		else $error("Single CRC failure did not set fault");
	chk_crc_off: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		!general_configuration[4] |-> !event_set[DCRB_EVT_CRC_FAULT])
		else $error("CRC fault with checking off");
	chk_clock_out_off: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		!general_configuration[11] |=> !CLOCK_OUTPUT_PIN_OUT)
		else $error("Clock output active while disabled");
	chk_break_irq: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		general_configuration[9] && break_mode && irq_pending |=> !UART_TRANSMIT_OUTPUT_OUT)
		else $error("Interrupt not sent as break");
	chk_irq_pin_off: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		!general_configuration[8] && !general_configuration[3] ##1 !general_configuration[3] |-> IRQ_PIN_OUT)
		else $error("Interrupt pin active while disabled");
	chk_irq_level: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		general_configuration[8] && general_configuration[2] && irq_pending && general_configuration[3]
		|=> IRQ_PIN_OUT)
		else $error("Level interrupt not held");
	chk_sdo_tristate: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		general_configuration[1] |-> SDO_OE_N_OUT)
		else $error("Serial output driven while tristated");
	cov_crc_fault: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		event_set[DCRB_EVT_CRC_FAULT]);
	cov_break_sent: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		!UART_TRANSMIT_OUTPUT_OUT && irq_pending);
	cov_clear_req: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		CLEAR_STATE_OUT);
endmodule
`default_nettype wire

/* File: dcrb_register_bank_tb_top.sv */
// Self-checking testbench of the DAC configuration register bank
`timescale 1ns/1ps
`default_nettype none
module dcrb_register_bank_tb_top;
	import dcrb_pkg::*;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic clk_sys = 1'b0;
	logic rst_n, wr_s, rd_s, osc, osc_run, uart_tx, sdi, sdo_data;
	logic [5:0] addr;
	logic [15:0] wdata, rdata, code;
	logic crc_en, clk_pin, uart_out, uart_en, baud, clr_st, sdo, sdo_oe_n, irq_pin, int_o;
	logic sclk, cs_n, done, bad;
	int n_fail = 0;
	int cmp_count = 0;
	// Clock and oscillator stimulus
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (osc_run) osc <= ~osc;
	dcrb_register_bank dcrb_register_bank_inst (.CLK_SYS_IN(clk_sys), .RST_N_IN(rst_n), .REG_ADDR_IN(addr),
		.REG_WDATA_IN(wdata), .REG_WR_IN(wr_s), .REG_RD_IN(rd_s), .REG_RDATA_OUT(rdata),
		.CRC_FRAME_DONE_IN(done), .CRC_FRAME_BAD_IN(bad), .CRC_CHECK_ENABLE_OUT(crc_en), .OSC_LEVEL_IN(osc),
		.CLOCK_OUTPUT_PIN_OUT(clk_pin), .UART_TX_DATA_IN(uart_tx), .UART_TRANSMIT_OUTPUT_OUT(uart_out),
		.UART_ENABLE_OUT(uart_en), .UART_BAUD_9600_OUT(baud), .SDI_IN(sdi), .CLEAR_STATE_OUT(clr_st),
		.SCLK_IN(sclk), .CS_N_IN(cs_n), .SDO_DATA_IN(sdo_data), .SDO_OUT(sdo), .SDO_OE_N_OUT(sdo_oe_n),
		.IRQ_PIN_OUT(irq_pin), .INT_OUT(int_o), .VOLTAGE_OUTPUT_CODE_OUT(code));
	dcrb_host_model dcrb_host_model_inst (.clk_in(clk_sys), .sclk_out(sclk), .cs_n_out(cs_n), .done_out(done),
		.bad_out(bad));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic nap(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk_sys);
		wr_s <= 1'b0;
		#1;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [5:0] a, input logic [15:0] exp);
		@(posedge clk_sys);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_sys);
		rd_s <= 1'b0;
		#1;
		chk("read data", rdata, exp);
	endtask
	task automatic toggles(input int n, output int c);
		logic p;
		c = 0;
		p = clk_pin;
		repeat (n) begin
			nap(1);
			if (clk_pin !== p) c++;
			p = clk_pin;
		end
	endtask
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		rd(DCRB_OFS_DAC_OUTPUT_CODE, DCRB_RST_DAC_OUTPUT_CODE);
		rd(DCRB_OFS_GENERAL_CONFIGURATION, 16'h0036);
		chk("clock pin", 16'(clk_pin), 16'h0000);
		chk("sdo enable", 16'(sdo_oe_n), 16'h0001);
		chk("irq pin", 16'(irq_pin), 16'h0001);
		chk("crc enable", 16'(crc_en), 16'h0001);
		chk("uart enable", 16'(uart_en), 16'h0001);
		chk("baud", 16'(baud), 16'h0001);
		$display("test reset done");
	endtask
	task automatic t_regs;
		wr(6'h00, 16'hffff);
		rd(6'h02, 16'h0036);
		wr(6'h01, 16'ha5c3);
		wr(6'h00, 16'h1234);
		rd(6'h01, 16'ha5c3);
		chk("code out", code, 16'ha5c3);
		// Write and read back with no gap between the strobes
		@(posedge clk_sys);
		addr <= 6'h01;
		wdata <= 16'h3c5a;
		wr_s <= 1'b1;
		@(posedge clk_sys);
		wr_s <= 1'b0;
		rd_s <= 1'b1;
		@(posedge clk_sys);
		rd_s <= 1'b0;
		#1;
		chk("write then read", rdata, 16'h3c5a);
		rd(6'h00, 16'h0000);
		rd(6'h3f, 16'h0000);
		wr(6'h02, 16'hffff);
		rd(6'h02, 16'h7bff);
		wr(6'h02, 16'h0000);
		rd(6'h02, 16'h0000);
		chk("crc enable", 16'(crc_en), 16'h0000);
		chk("baud", 16'(baud), 16'h0000);
		wr(6'h02, 16'h0040);
		chk("uart enable", 16'(uart_en), 16'h0000);
		$display("test registers done");
	endtask
	task automatic t_crc;
		for (int t = 0; t < 4; t++) begin
			wr(6'h02, 16'h0010 | 16'(t << 13));
			dcrb_host_model_inst.frame(1'b0);
			wr(6'h31, 16'h0003);
			repeat ((1 << t) - 1) dcrb_host_model_inst.frame(1'b1);
			rd(6'h30, 16'h0000);
			dcrb_host_model_inst.frame(1'b1);
			rd(6'h30, 16'h0001);
		end
		wr(6'h02, 16'h0000);
		wr(6'h31, 16'h0003);
		dcrb_host_model_inst.frame(1'b1);
		rd(6'h30, 16'h0000);
		$display("test crc done");
	endtask
	task automatic t_irq;
		int lows;
		wr(6'h32, 16'h0001);
		wr(6'h02, 16'h0010);
		// A good frame ends the run left over from earlier tests
		dcrb_host_model_inst.frame(1'b0);
		dcrb_host_model_inst.frame(1'b1);
		nap(2);
		chk("int", 16'(int_o), 16'h0001);
		chk("irq pin", 16'(irq_pin), 16'h0001);
		wr(6'h02, 16'h0114);
		nap(2);
		chk("irq pin", 16'(irq_pin), 16'h0000);
		wr(6'h02, 16'h011c);
		nap(2);
		chk("irq pin", 16'(irq_pin), 16'h0001);
		@(posedge clk_sys);
		uart_tx <= 1'b1;
		wr(6'h02, 16'h0234);
		nap(2);
		chk("uart out", 16'(uart_out), 16'h0000);
		wr(6'h32, 16'h0000);
		chk("int", 16'(int_o), 16'h0000);
		wr(6'h32, 16'h0001);
		wr(6'h31, 16'h0001);
		chk("int", 16'(int_o), 16'h0000);
		wr(6'h02, 16'h0110);
		dcrb_host_model_inst.frame(1'b0);
		dcrb_host_model_inst.frame(1'b1);
		lows = 0;
		repeat (8) begin
			nap(1);
			if (irq_pin === 1'b0) lows++;
		end
		chk("edge pulse", 16'(lows), 16'h0001);
		$display("test interrupt done");
	endtask
	task automatic t_pins;
		wr(6'h02, 16'h0030);
		@(posedge clk_sys);
		uart_tx <= 1'b0;
		nap(2);
		chk("uart out", 16'(uart_out), 16'h0000);
		wr(6'h02, 16'h0070);
		nap(2);
		chk("uart out", 16'(uart_out), 16'h0001);
		wr(6'h31, 16'h0003);
		wr(6'h02, 16'h00b0);
		@(posedge clk_sys);
		sdi <= 1'b1;
		nap(3);
		chk("clear", 16'(clr_st), 16'h0001);
		rd(6'h30, 16'h0002);
		// Clear follows the serial input level
		@(posedge clk_sys);
		sdi <= 1'b0;
		nap(2);
		chk("clear", 16'(clr_st), 16'h0000);
		@(posedge clk_sys);
		sdi <= 1'b1;
		nap(2);
		chk("clear", 16'(clr_st), 16'h0001);
		wr(6'h02, 16'h0030);
		nap(2);
		chk("clear", 16'(clr_st), 16'h0000);
		@(posedge clk_sys);
		sdo_data <= 1'b1;
		dcrb_host_model_inst.pins(1'b0, 1'b0);
		chk("sdo enable", 16'(sdo_oe_n), 16'h0000);
		dcrb_host_model_inst.pins(1'b1, 1'b0);
		chk("sdo", 16'(sdo), 16'h0001);
		@(posedge clk_sys);
		sdo_data <= 1'b0;
		dcrb_host_model_inst.pins(1'b0, 1'b0);
		chk("sdo", 16'(sdo), 16'h0001);
		wr(6'h02, 16'h0031);
		dcrb_host_model_inst.pins(1'b1, 1'b0);
		chk("sdo", 16'(sdo), 16'h0001);
		dcrb_host_model_inst.pins(1'b0, 1'b0);
		chk("sdo", 16'(sdo), 16'h0000);
		dcrb_host_model_inst.pins(1'b0, 1'b1);
		chk("sdo enable", 16'(sdo_oe_n), 16'h0001);
		wr(6'h02, 16'h0032);
		dcrb_host_model_inst.pins(1'b0, 1'b0);
		chk("sdo enable", 16'(sdo_oe_n), 16'h0001);
		dcrb_host_model_inst.pins(1'b0, 1'b1);
		$display("test pins done");
	endtask
	task automatic t_clkout;
		int c;
		@(posedge clk_sys);
		osc_run <= 1'b1;
		wr(6'h02, 16'h0830);
		nap(4);
		toggles(40, c);
		chk("undivided", 16'(c), 16'h0028);
		wr(6'h02, 16'h1830);
		nap(300);
		toggles(1024, c);
		chk("divided", 16'(c), 16'h0008);
		wr(6'h02, 16'h0030);
		nap(4);
		toggles(40, c);
		chk("disabled", 16'(c), 16'h0000);
		chk("clock pin", 16'(clk_pin), 16'h0000);
		$display("test clock out done");
	endtask
	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		wr_s = 1'b0;
		rd_s = 1'b0;
		osc = 1'b0;
		osc_run = 1'b0;
		uart_tx = 1'b1;
		sdi = 1'b0;
		sdo_data = 1'b0;
		addr = 6'h00;
		wdata = 16'h0000;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset;
		t_regs;
		t_crc;
		t_irq;
		t_pins;
		t_clkout;
		end_of_test;
	end
	initial begin
		#200000;
		n_fail++;
		end_of_test;
	end
endmodule
`default_nettype wire
